/* File: hpp_map.svh */
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH

// number of clock output drivers gated by this block
`define HPP_CLK_OUT_N 12
// width of the pin sample vector
`define HPP_PIN_W 8
// pin sample reset values: sclk, sda, a1, a0_cs, sel, pdn_n, rst_n, oe_dis
`define HPP_PIN_RST 8'hDE
// mode captured by a plain i_rst, strap pulled high
`define HPP_MODE_RST HPP_MODE_I2C
// core reset edges after i_rst, outlasting the filter latency
`define HPP_BOOT_CYC 3'h5
// drive levels
`define HPP_DRIVE_LOW 1'h0
`define HPP_IRQ_IDLE 1'h1

`endif

/* File: hpp_pkg.sv */
package hpp_pkg;

	// host port personality, caught while reset is in effect
	typedef enum logic [1:0] {
		HPP_MODE_I2C,
		HPP_MODE_SPI3,
		HPP_MODE_SPI4
	} hpp_mode_t;

	// synchronised view of the pins, msb first
	typedef struct packed {
		logic sclk;
		logic sda;
		logic a1;
		logic a0_cs;
		logic iface_sel;
		logic pdn_n;
		logic rst_n;
		logic oe_dis;
	} hpp_pins_t;

	// decoded host port state handed to the serial engine
	typedef struct packed {
		logic is_i2c;
		logic four_wire;
		logic sclk_level;
		logic sclk_rise;
		logic sclk_fall;
		logic data_in;
		logic cs_active;
		logic addr1;
		logic addr0;
	} hpp_port_t;

endpackage

/* File: hpp_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser with a two-stage agreement filter
module hpp_sync #(
	parameter int            W       = 8,
	parameter logic [W-1:0]  RST_VAL = '1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] ff1;         // metastable stage, read by ff2 only
	logic [W-1:0] ff2;         // second stage
	logic [W-1:0] ff3;         // third stage
	logic [W-1:0] stable;      // accepted level
	logic [W-1:0] agree;       // stage two and three match
	logic [W-1:0] next_stable; // accepted level, next

	// a bit moves only once stages two and three agree
	always_comb begin
		agree       = ~(ff2 ^ ff3);
		next_stable = (stable & ~agree) | (ff3 & agree);
	end

	// register stages; reset to the pulled levels
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ff1    <= RST_VAL;
			ff2    <= RST_VAL;
			ff3    <= RST_VAL;
			stable <= RST_VAL;
		end else begin
			ff1    <= i_async;
			ff2    <= ff1;
			ff3    <= ff2;
			stable <= next_stable;
		end
	end

	assign o_sync = stable;

endmodule

`default_nettype wire

/* File: hpp_pins.sv */
// Operation
// - strap high selects I2C, low SPI
// - undriven strap defaults to I2C
// - data pin SDA, SDIO, or input SDI
// - second pin address bit1 or data out
// - third pin is address bit0 in I2C
// - SPI third pin is active-low chip select
// - interrupt low after any status change
// - power-down low enters low power mode
// - reset low performs power-on reset
// - reset restores registers to defaults
// - clock outputs disabled during reset
// - output-disable high disables all outputs; here it gates only the clock driver enables
// - unconnected output-disable keeps outputs enabled
`timescale 1ns/100ps
`default_nettype none
`include "hpp_map.svh"

module hpp_pins
	import hpp_pkg::*;
#(
	parameter int N_CLK_OUT = `HPP_CLK_OUT_N
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_iface_sel_i2c,
	input  wire logic                 i_serial_clk,
	input  wire logic                 i_serial_data_pin,
	output logic                      o_serial_data_pin,
	output logic                      o_serial_data_pin_oe,
	input  wire logic                 i_addr_bit1_or_data_out_pin,
	output logic                      o_addr_bit1_or_data_out_pin,
	output logic                      o_addr_bit1_or_data_out_pin_oe,
	input  wire logic                 i_addr_bit0_or_chip_select_n_pin,
	input  wire logic                 i_power_down_n,
	input  wire logic                 i_device_reset_n,
	input  wire logic                 i_all_outputs_disable,
	output logic                      o_status_change_irq_n,
	input  wire logic                 i_spi_four_wire,
	input  wire logic                 i_tx_bit,
	input  wire logic                 i_tx_en,
	input  wire logic                 i_status_event,
	input  wire logic                 i_status_clear,
	output hpp_port_t                 o_port,
	output logic                      o_low_power,
	output logic                      o_core_reset,
	output logic      [N_CLK_OUT-1:0] o_clk_out_en
);

	logic [`HPP_PIN_W-1:0] pin_raw;   // raw pin levels
	logic [`HPP_PIN_W-1:0] pin_sync;  // filtered pin levels
	hpp_pins_t             pins_s;    // filtered levels by name
	logic                  core_rst;  // device reset in effect
	logic                  cs_act;    // spi chip select asserted

	hpp_mode_t             mode;      // captured personality
	hpp_mode_t             next_mode; // personality, next
	logic                  sclk_prev; // last filtered serial clock
	hpp_port_t             next_port; // engine view, next
	logic [2:0]            boot_cnt;      // filter warm-up after i_rst
	logic [2:0]            next_boot_cnt; // warm-up, next

	logic                  next_sda;     // data pin level, next
	logic                  next_sda_oe;  // data pin enable, next
	logic                  next_a1;      // second pin level, next
	logic                  next_a1_oe;   // second pin enable, next
	logic                  next_irq_n;   // interrupt pin, next
	logic                  next_low_pwr; // low power flag, next
	logic                  next_core_rst;
	logic [N_CLK_OUT-1:0]  next_clk_en;  // clock driver enables

	// gather every outside level; the serial clock is only sampled
	always_comb begin
		pin_raw = {i_serial_clk,
			i_serial_data_pin,
			i_addr_bit1_or_data_out_pin,
			i_addr_bit0_or_chip_select_n_pin,
			i_iface_sel_i2c,
			i_power_down_n,
			i_device_reset_n,
			i_all_outputs_disable};
	end

	// all pins cross through the filter; reset values model pulls
	hpp_sync #(
		.W       (`HPP_PIN_W),
		.RST_VAL (`HPP_PIN_RST)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (pin_raw),
		.o_sync  (pin_sync)
	);

	assign pins_s = hpp_pins_t'(pin_sync);

	// reset pin acts only once filtered, so a glitch cannot fire it
	// held through filter warm-up so a low strap is caught at power-up
	assign core_rst = i_rst | ~pins_s.rst_n
		| (boot_cnt != 3'h0);

	// chip select is meaningful only outside I2C
	assign cs_act = (mode != HPP_MODE_I2C) & ~pins_s.a0_cs;

	// personality follows the strap only while reset is in effect,
	// so a strap wiggle during traffic cannot flip the port
	always_comb begin
		next_mode = mode;
		next_boot_cnt = (boot_cnt == 3'h0) ? 3'h0 : boot_cnt - 3'h1;
		if (core_rst) begin
			if (pins_s.iface_sel) begin
				next_mode = HPP_MODE_I2C;
			end else if (i_spi_four_wire) begin
				next_mode = HPP_MODE_SPI4;
			end else begin
				next_mode = HPP_MODE_SPI3;
			end
		end
	end

	// mode register; plain reset means a pulled-high strap
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode     <= `HPP_MODE_RST;
			boot_cnt <= `HPP_BOOT_CYC;
		end else begin
			mode     <= next_mode;
			boot_cnt <= next_boot_cnt;
		end
	end

	// pin roles per personality
	always_comb begin
		next_sda    = `HPP_DRIVE_LOW;
		next_sda_oe = 1'h0;
		next_a1     = i_tx_bit;
		next_a1_oe  = 1'h0;
		if (!core_rst) begin
			case (mode)
				HPP_MODE_I2C: begin
					// open drain: only ever pull low
					next_sda_oe = i_tx_en & ~i_tx_bit;
				end
				HPP_MODE_SPI3: begin
					// sdio turns round under chip select
					next_sda    = i_tx_bit;
					next_sda_oe = i_tx_en & cs_act;
				end
				HPP_MODE_SPI4: begin
					// data pin stays input, second pin drives
					next_a1_oe  = i_tx_en & cs_act;
				end
				default: begin
					next_sda_oe = 1'h0;
				end
			endcase
		end
	end

	// decoded view for the serial engine
	always_comb begin
		next_port            = '0;
		next_port.is_i2c     = (mode == HPP_MODE_I2C);
		next_port.four_wire  = (mode == HPP_MODE_SPI4);
		next_port.sclk_level = pins_s.sclk;
		next_port.sclk_rise  = pins_s.sclk & ~sclk_prev;
		next_port.sclk_fall  = ~pins_s.sclk & sclk_prev;
		next_port.data_in    = pins_s.sda;
		next_port.cs_active  = cs_act;
		// address straps read as zero outside I2C
		next_port.addr1 = next_port.is_i2c & pins_s.a1;
		next_port.addr0 = next_port.is_i2c & pins_s.a0_cs;
	end

	// control and status outputs
	always_comb begin
		// set beats clear, so a late event is never lost
		next_irq_n = o_status_change_irq_n;
		if (core_rst) begin
			next_irq_n = `HPP_IRQ_IDLE;
		end else if (i_status_event) begin
			next_irq_n = `HPP_DRIVE_LOW;
		end else if (i_status_clear) begin
			next_irq_n = `HPP_IRQ_IDLE;
		end
		next_low_pwr  = ~pins_s.pdn_n;
		next_core_rst = core_rst;
		// drivers off in reset, low power, or when disabled
		if (core_rst | pins_s.oe_dis | ~pins_s.pdn_n) begin
			next_clk_en = '0;
		end else begin
			next_clk_en = '1;
		end
	end

	// output registers; every output leaves from a flop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sclk_prev                      <= 1'h1;
			o_port                         <= '0;
			o_serial_data_pin              <= `HPP_DRIVE_LOW;
			o_serial_data_pin_oe           <= 1'h0;
			o_addr_bit1_or_data_out_pin    <= `HPP_DRIVE_LOW;
			o_addr_bit1_or_data_out_pin_oe <= 1'h0;
			o_status_change_irq_n          <= `HPP_IRQ_IDLE;
			o_low_power                    <= 1'h0;
			o_core_reset                   <= 1'h1;
			o_clk_out_en                   <= '0;
		end else begin
			sclk_prev                      <= pins_s.sclk;
			o_port                         <= next_port;
			o_serial_data_pin              <= next_sda;
			o_serial_data_pin_oe           <= next_sda_oe;
			o_addr_bit1_or_data_out_pin    <= next_a1;
			o_addr_bit1_or_data_out_pin_oe <= next_a1_oe;
			o_status_change_irq_n          <= next_irq_n;
			o_low_power                    <= next_low_pwr;
			o_core_reset                   <= next_core_rst;
			o_clk_out_en                   <= next_clk_en;
		end
	end

	// strap sampled in reset decides the personality
	property p_mode_sel;
		@(posedge i_clk) disable iff (i_rst)
		core_rst |=> (mode == HPP_MODE_I2C) == $past(pins_s.iface_sel);
	endproperty
	a_mode_sel: assert property (p_mode_sel)
		else $error("mode does not follow strap");

	// plain reset leaves the port in I2C
	property p_mode_dflt;
		@(posedge i_clk)
		i_rst ##1 !i_rst |-> mode == HPP_MODE_I2C;
	endproperty
	a_mode_dflt: assert property (p_mode_dflt)
		else $error("mode not I2C after reset");

	// sdio drives the engine bit under chip select
	property p_sdio;
		@(posedge i_clk) disable iff (i_rst)
		(mode == HPP_MODE_SPI3 && cs_act && i_tx_en && !core_rst)
		|=> o_serial_data_pin_oe && o_serial_data_pin == $past(i_tx_bit);
	endproperty
	a_sdio: assert property (p_sdio)
		else $error("sdio not driven");

	// 4-wire data pin is never driven
	property p_sdi_in;
		@(posedge i_clk) disable iff (i_rst)
		mode == HPP_MODE_SPI4 |=> !o_serial_data_pin_oe;
	endproperty
	a_sdi_in: assert property (p_sdi_in)
		else $error("sdi driven");

	// second pin only drives in 4-wire
	property p_a1_role;
		@(posedge i_clk) disable iff (i_rst)
		mode != HPP_MODE_SPI4 |=> !o_addr_bit1_or_data_out_pin_oe;
	endproperty
	a_a1_role: assert property (p_a1_role)
		else $error("address pin driven");

	// address bit0 follows the pin in I2C
	property p_addr0;
		@(posedge i_clk) disable iff (i_rst)
		mode == HPP_MODE_I2C ##1 mode == HPP_MODE_I2C
		|-> o_port.addr0 == $past(pins_s.a0_cs);
	endproperty
	a_addr0: assert property (p_addr0)
		else $error("addr0 wrong");

	// deselected spi never drives either pin
	property p_cs_off;
		@(posedge i_clk) disable iff (i_rst)
		(mode != HPP_MODE_I2C && pins_s.a0_cs) |=>
		!o_serial_data_pin_oe && !o_addr_bit1_or_data_out_pin_oe;
	endproperty
	a_cs_off: assert property (p_cs_off)
		else $error("driven while deselected");

	// an event pulls the interrupt low on the next cycle
	property p_irq;
		@(posedge i_clk) disable iff (i_rst)
		(i_status_event && !core_rst) |=> !o_status_change_irq_n;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not asserted");

	// filtered power-down low gives low power and no clocks
	property p_pdn;
		@(posedge i_clk) disable iff (i_rst)
		!pins_s.pdn_n |=> o_low_power && o_clk_out_en == '0;
	endproperty
	a_pdn: assert property (p_pdn)
		else $error("power down ignored");

	// reset pin held low four cycles puts core in reset
	property p_rst_pin;
		@(posedge i_clk) disable iff (i_rst)
		!i_device_reset_n [*4] |=> core_rst;
	endproperty
	a_rst_pin: assert property (p_rst_pin)
		else $error("reset pin not seen");

	// register defaults requested through the core reset
	property p_core_rst;
		@(posedge i_clk) disable iff (i_rst)
		core_rst |=> o_core_reset && o_clk_out_en == '0;
	endproperty
	a_core_rst: assert property (p_core_rst)
		else $error("reset not propagated");

	// disable high shuts the drivers
	property p_oe_dis;
		@(posedge i_clk) disable iff (i_rst)
		pins_s.oe_dis |=> o_clk_out_en == '0;
	endproperty
	a_oe_dis: assert property (p_oe_dis)
		else $error("outputs not disabled");

	// disable low and running keeps drivers on
	property p_oe_on;
		@(posedge i_clk) disable iff (i_rst)
		(!pins_s.oe_dis && pins_s.pdn_n && !core_rst)
		|=> o_clk_out_en == '1;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("outputs not enabled");

endmodule

`default_nettype wire

/* File: hpp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// host controller: owns serial clock, chip select and its data drive
module hpp_host_model (
	input  wire logic i_clk,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_data,
	output logic      o_data_oe
);
	// idle: clock still, select released high by its pull-up
	initial begin
		o_sclk    = 1'h0;
		o_cs_n    = 1'h1;
		o_data    = 1'h0;
		o_data_oe = 1'h0;
	end

	// chip select level in spi mode; in i2c mode the same pin is address bit0
	task automatic sel(input logic on);
		@(negedge i_clk);
		o_cs_n = ~on;
	endtask

	// eight bits, msb first, 160 ns clock only inside the frame
	task automatic frame(input logic spi, input logic [7:0] bits);
		@(negedge i_clk);
		o_cs_n = ~spi;
		for (int i = 7; i >= 0; i--) begin
			// i2c is open drain: only ever pulls low
			o_data_oe = spi | ~bits[i];
			o_data    = spi & bits[i];
			repeat (4) @(negedge i_clk);
			o_sclk = 1'h1;
			repeat (4) @(negedge i_clk);
			o_sclk = 1'h0;
		end
		repeat (4) @(negedge i_clk);
		o_cs_n    = 1'h1;
		o_data_oe = 1'h0;
	endtask
endmodule

`default_nettype wire

/* File: test_host_port_mode_and_control_pins.sv */
`timescale 1ns/100ps
`default_nettype none

module test_host_port_mode_and_control_pins
	import hpp_pkg::*;
;
	localparam int NCO = 12;
	logic            i_clk, i_rst, sel, pdn_n, rst_n, dis, four;
	logic            tx_bit, tx_en, ev, clr, a1_lvl, tog;
	logic            d_val, d_oe, s_val, s_oe, irq_n, low_pwr, core_rst;
	logic            h_sclk, h_cs_n, h_d, h_oe, sda_w, a1_w;
	logic [NCO-1:0]  clk_en;
	hpp_port_t       port_s;
	int              n_fail, comparisons, n_rise, n_fall;
	logic [7:0]      rx;
	logic            lvl_rise;

	// released spi line must not look stable, so it toggles
	always @(posedge i_clk) tog <= ~tog;
	assign sda_w = d_oe ? d_val : h_oe ? h_d : (sel ? 1'h1 : tog);
	assign a1_w  = s_oe ? s_val : a1_lvl;

	// clock; edge counts and bit capture from the decoded serial clock
	always #10 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (port_s.sclk_rise === 1'h1) begin
			n_rise   <= n_rise + 1;
			lvl_rise <= port_s.sclk_level;
			rx       <= {rx[6:0], port_s.data_in};
		end
		if (port_s.sclk_fall === 1'h1) begin
			n_fall <= n_fall + 1;
		end
	end

	hpp_host_model host_u (.i_clk(i_clk), .o_sclk(h_sclk), .o_cs_n(h_cs_n),
		.o_data(h_d), .o_data_oe(h_oe));

	hpp_pins dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_iface_sel_i2c(sel),
		.i_serial_clk(h_sclk), .i_serial_data_pin(sda_w),
		.o_serial_data_pin(d_val), .o_serial_data_pin_oe(d_oe),
		.i_addr_bit1_or_data_out_pin(a1_w),
		.o_addr_bit1_or_data_out_pin(s_val),
		.o_addr_bit1_or_data_out_pin_oe(s_oe),
		.i_addr_bit0_or_chip_select_n_pin(h_cs_n), .i_power_down_n(pdn_n),
		.i_device_reset_n(rst_n), .i_all_outputs_disable(dis),
		.o_status_change_irq_n(irq_n), .i_spi_four_wire(four),
		.i_tx_bit(tx_bit), .i_tx_en(tx_en), .i_status_event(ev),
		.i_status_clear(clr), .o_port(port_s), .o_low_power(low_pwr),
		.o_core_reset(core_rst), .o_clk_out_en(clk_en));

	// one compare, four-state so an unknown never matches
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// pin filters take four edges, the output flop a fifth; leave margin
	task automatic settle(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// strap pulled high, disable pulled low, power-down pulled up
	task automatic t_defaults();
		check("is_i2c", port_s.is_i2c, 16'h1);
		check("core_reset", core_rst, 16'h0);
		check("clk_en", clk_en, 16'hFFF);
		check("irq_n idle", irq_n, 16'h1);
		check("low_power", low_pwr, 16'h0);
	endtask

	// address straps and open-drain drive in i2c mode
	task automatic t_i2c();
		a1_lvl = 1'h1;
		settle(8);
		check("addr1", port_s.addr1, 16'h1);
		check("addr0", port_s.addr0, 16'h1);
		check("data_in released", port_s.data_in, 16'h1);
		host_u.sel(1'h1);
		settle(8);
		check("addr0 low", port_s.addr0, 16'h0);
		host_u.sel(1'h0);
		a1_lvl = 1'h0;
		tx_en  = 1'h1;
		tx_bit = 1'h0;
		settle(8);
		check("addr1 low", port_s.addr1, 16'h0);
		check("sda oe", d_oe, 16'h1);
		check("sda low", d_val, 16'h0);
		check("a1 not driven", s_oe, 16'h0);
		tx_bit = 1'h1;
		settle(1);
		check("sda released", d_oe, 16'h0);
		tx_en = 1'h0;
	endtask

	// a whole byte from the host: rises counted, bits captured
	task automatic t_frame(input logic spi, input logic [7:0] b);
		n_rise   = 0;
		n_fall   = 0;
		lvl_rise = 1'h0;
		host_u.frame(spi, b);
		settle(8);
		check("sclk rises", 16'(n_rise), 16'h8);
		check("sclk falls", 16'(n_fall), 16'h8);
		check("level at rise", lvl_rise, 16'h1);
		check("level idle", port_s.sclk_level, 16'h0);
		check("rx byte", rx, 16'(b));
	endtask

	// sticky interrupt, set wins over a clear in the same cycle
	task automatic t_irq();
		ev = 1'h1;
		settle(1);
		ev = 1'h0;
		check("irq set", irq_n, 16'h0);
		settle(3);
		check("irq holds", irq_n, 16'h0);
		clr = 1'h1;
		settle(1);
		check("irq cleared", irq_n, 16'h1);
		ev = 1'h1;
		settle(1);
		ev  = 1'h0;
		clr = 1'h0;
		check("set wins", irq_n, 16'h0);
	endtask

	// one-cycle glitch ignored, held level acted on
	task automatic t_pdn();
		pdn_n = 1'h0;
		settle(1);
		pdn_n = 1'h1;
		for (int i = 0; i < 8; i++) begin
			settle(1);
			check("glitch", low_pwr, 16'h0);
		end
		pdn_n = 1'h0;
		settle(8);
		check("low power", low_pwr, 16'h1);
		check("clk_en pdn", clk_en, 16'h0);
		pdn_n = 1'h1;
		dis   = 1'h1;
		settle(8);
		check("clk_en dis", clk_en, 16'h0);
		dis = 1'h0;
		settle(8);
		check("clk_en back", clk_en, 16'hFFF);
	endtask

	// device reset clears irq, gates outputs, recaptures the strap
	task automatic t_dev_reset(input logic s, input logic f);
		ev = 1'h1;
		settle(1);
		ev    = 1'h0;
		rst_n = 1'h0;
		sel   = s;
		four  = f;
		settle(10);
		check("core_reset", core_rst, 16'h1);
		check("clk_en rst", clk_en, 16'h0);
		check("irq default", irq_n, 16'h1);
		rst_n = 1'h1;
		settle(10);
		check("core_reset off", core_rst, 16'h0);
		check("mode", port_s.is_i2c, 16'(s));
		if (!s) check("four_wire", port_s.four_wire, 16'(f));
	endtask

	// spi drive only while selected, pin by wire count
	task automatic t_spi(input logic f);
		host_u.sel(1'h1);
		settle(8);
		check("cs_active", port_s.cs_active, 16'h1);
		check("addr spi", {port_s.addr1, port_s.addr0}, 16'h0);
		tx_en  = 1'h1;
		tx_bit = 1'h1;
		settle(1);
		check("sdo oe", s_oe, 16'(f));
		check("sdio oe", d_oe, 16'(!f));
		check("bit", f ? s_val : d_val, 16'h1);
		tx_bit = 1'h0;
		settle(1);
		check("bit0", f ? s_val : d_val, 16'h0);
		host_u.sel(1'h0);
		settle(8);
		check("no drive", {s_oe, d_oe}, 16'h0);
		tx_en = 1'h0;
	endtask

	// mid-run power-up reset: a low strap must still give spi
	task automatic t_power_up(input logic s, input logic f);
		sel   = s;
		four  = f;
		i_rst = 1'h1;
		settle(6);
		i_rst = 1'h0;
		settle(3);
		check("core_reset held", core_rst, 16'h1);
		settle(7);
		check("core_reset boot", core_rst, 16'h0);
		check("mode boot", port_s.is_i2c, 16'(s));
		check("four_wire boot", port_s.four_wire, 16'(f));
	endtask

	initial begin
		{i_clk, tog, sel, pdn_n, rst_n, i_rst} = 6'h3F;
		{dis, four, tx_bit, tx_en, ev, clr, a1_lvl} = 7'h00;
		{n_fail, comparisons, n_rise, n_fall} = '0;
		rx = 8'h00;
		settle(6);
		i_rst = 1'h0;
		settle(8);
		t_defaults();
		t_i2c();
		t_frame(1'h0, 8'hA5);
		t_irq();
		t_pdn();
		t_dev_reset(1'h0, 1'h1);
		t_spi(1'h1);
		t_frame(1'h1, 8'h3C);
		t_dev_reset(1'h0, 1'h0);
		t_spi(1'h0);
		t_frame(1'h1, 8'hC3);
		t_dev_reset(1'h1, 1'h0);
		t_power_up(1'h0, 1'h1);
		tally_and_finish();
	end

	// hang guard, well beyond the roughly 430 cycles of the run
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
